//--- rtl/smcc_pkg.sv
package smcc_pkg;

   // Core clock and the two-wire primary bit rate
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned SCL_HZ = 100_000;
   // Four phases per bit; rounded down so the bus never runs slower than planned
   localparam int unsigned QTR_CYC = CLK_HZ / (4 * SCL_HZ);
   localparam logic [7:0] QTR_CNT = 8'(QTR_CYC - 1);

   // Decoded five-level pin value
   typedef logic [2:0] smcc_level_t;
   localparam smcc_level_t LVL_L0 = 3'h0;
   localparam smcc_level_t LVL_L1 = 3'h1;
   localparam smcc_level_t LVL_L2 = 3'h2;
   localparam smcc_level_t LVL_L4 = 3'h4;

   // Power-up straps, three bits each in the packed strap vector
   localparam int unsigned NSTRAP = 7;
   localparam int unsigned ST_B0LO = 0;
   localparam int unsigned ST_B0HI = 1;
   localparam int unsigned ST_B1LO = 2;
   localparam int unsigned ST_B1HI = 3;
   localparam int unsigned ST_G0 = 4;
   localparam int unsigned ST_G1 = 5;
   localparam int unsigned ST_RXD = 6;

   // Configuration register file, reachable by the secondary and the EEPROM load
   localparam int unsigned CFG_REGS = 4;
   localparam logic [1:0] REG_BOOST0 = 2'h0;
   localparam logic [1:0] REG_BOOST1 = 2'h1;
   localparam logic [1:0] REG_GAIN = 2'h2;
   localparam logic [1:0] REG_RXDET = 2'h3;
   localparam logic [7:0] CFG_RST = 8'h00;

   // External EEPROM and own secondary address base
   localparam logic [6:0] EEPROM_ADDR = 7'h50;
   localparam logic [7:0] EEPROM_START_OFS = 8'h00;
   localparam logic [6:0] SEC_ADDR_BASE = 7'h18;
   // Bytes: address write, offset, address read, then CFG_REGS data bytes
   localparam logic [2:0] BYTE_FIRST_RD = 3'h3;
   localparam logic [2:0] BYTE_LAST = 3'h6;

   typedef enum {M_IDLE, M_START, M_BITS, M_STOP, M_DONE, M_FAIL} smcc_mstate_t;
   typedef enum {S_IDLE, S_ADDR, S_PTR, S_WDATA, S_RDATA} smcc_sstate_t;

   // Out-of-range codes read as the floating level
   function automatic smcc_level_t lvl_clamp(input smcc_level_t l);
      return (l > LVL_L4) ? LVL_L4 : l;
   endfunction

   // Two five-level pins form one of 25 settings
   function automatic logic [4:0] pair_index(input smcc_level_t lo, input smcc_level_t hi);
      return {2'h0, hi} * 5'h05 + {2'h0, lo};
   endfunction

endpackage

//--- rtl/smcc_strap_latch.sv
module smcc_strap_latch (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Raw strap levels
   input wire logic [smcc_pkg::NSTRAP*3-1:0] strap_raw,
   // Held strap levels
   output logic [smcc_pkg::NSTRAP*3-1:0] strap_held,
   output logic captured
);

   logic captured_reg;

   // Capture happens in the first cycle after release, so reset never loads a pin
   always_ff @(posedge clock) begin
      if (reset) begin
         captured_reg <= 1'b0;
      end else begin
         captured_reg <= 1'b1;
      end
   end

   genvar i;
   generate
      for (i = 0; i < smcc_pkg::NSTRAP; i++) begin : g_strap
         smcc_pkg::smcc_level_t lvl_reg;
         always_ff @(posedge clock) begin
            if (reset) begin
               lvl_reg <= smcc_pkg::LVL_L0;
            end else if (!captured_reg) begin
               lvl_reg <= smcc_pkg::lvl_clamp(strap_raw[i*3 +: 3]);
            end
         end
         assign strap_held[i*3 +: 3] = lvl_reg;
      end
   endgenerate

   assign captured = captured_reg;

endmodule

//--- rtl/smcc_secondary.sv
module smcc_secondary (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Control
   input wire logic enable,
   input wire logic [6:0] dev_addr,
   // Bus lines
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_pull,
   output logic busy,
   // Register file access
   output logic wr_en,
   output logic [1:0] wr_idx,
   output logic [7:0] wr_data,
   output logic [1:0] rd_idx,
   input wire logic [7:0] rd_data
);

   smcc_pkg::smcc_sstate_t st_reg;
   logic scl_q, sda_q, rw_reg;
   logic [3:0] bitc_reg;
   logic [7:0] sh_reg;
   wire start_seen = scl_in & scl_q & sda_q & ~sda_in;
   wire stop_seen = scl_in & scl_q & ~sda_q & sda_in;
   wire scl_rise = scl_in & ~scl_q;
   wire scl_fall = ~scl_in & scl_q;
   wire addr_hit = enable & (sh_reg[7:1] == dev_addr);

   always_ff @(posedge clock) begin
      if (reset) begin
         st_reg <= smcc_pkg::S_IDLE;
         {scl_q, sda_q} <= 2'h3;
         {rw_reg, sda_pull, busy, wr_en} <= 4'h0;
         bitc_reg <= 4'h0;
         sh_reg <= 8'h00;
         wr_idx <= 2'h0;
         wr_data <= 8'h00;
         rd_idx <= 2'h0;
      end else begin
         {scl_q, sda_q} <= {scl_in, sda_in};
         wr_en <= 1'b0;
         if (start_seen) begin
            st_reg <= smcc_pkg::S_ADDR;
            bitc_reg <= 4'hf;
            busy <= 1'b1;
            sda_pull <= 1'b0;
         end else if (stop_seen) begin
            st_reg <= smcc_pkg::S_IDLE;
            busy <= 1'b0;
            sda_pull <= 1'b0;
         end else if (st_reg != smcc_pkg::S_IDLE) begin
            if (scl_rise && st_reg != smcc_pkg::S_RDATA && bitc_reg < 4'h8) begin
               sh_reg <= {sh_reg[6:0], sda_in};
            end
            if (scl_rise && st_reg == smcc_pkg::S_RDATA && bitc_reg == 4'h8 && sda_in) begin
               st_reg <= smcc_pkg::S_IDLE;
            end
            if (scl_fall) begin
               bitc_reg <= (bitc_reg == 4'h8) ? 4'h0 : bitc_reg + 4'h1;
               case (st_reg)
                  smcc_pkg::S_ADDR: begin
                     if (bitc_reg == 4'h7) begin
                        sda_pull <= addr_hit;
                        rw_reg <= sh_reg[0];
                        if (!addr_hit) begin
                           st_reg <= smcc_pkg::S_IDLE;
                        end
                     end else if (bitc_reg == 4'h8) begin
                        sda_pull <= rw_reg & ~rd_data[7];
                        sh_reg <= rd_data;
                        st_reg <= rw_reg ? smcc_pkg::S_RDATA : smcc_pkg::S_PTR;
                     end
                  end
                  smcc_pkg::S_PTR: begin
                     sda_pull <= (bitc_reg == 4'h7);
                     if (bitc_reg == 4'h7) begin
                        rd_idx <= sh_reg[1:0];
                     end else if (bitc_reg == 4'h8) begin
                        st_reg <= smcc_pkg::S_WDATA;
                     end
                  end
                  smcc_pkg::S_WDATA: begin
                     sda_pull <= (bitc_reg == 4'h7);
                     if (bitc_reg == 4'h7) begin
                        wr_en <= 1'b1;
                        wr_idx <= rd_idx;
                        wr_data <= sh_reg;
                     end else if (bitc_reg == 4'h8) begin
                        rd_idx <= rd_idx + 2'h1;
                     end
                  end
                  smcc_pkg::S_RDATA: begin
                     if (bitc_reg < 4'h7) begin
                        sda_pull <= ~sh_reg[6];
                        sh_reg <= {sh_reg[6:0], 1'b0};
                     end else if (bitc_reg == 4'h7) begin
                        sda_pull <= 1'b0;
                        rd_idx <= rd_idx + 2'h1;
                     end else begin
                        sda_pull <= ~rd_data[7];
                        sh_reg <= rd_data;
                     end
                  end
                  default: begin
                     st_reg <= smcc_pkg::S_IDLE;
                  end
               endcase
            end
         end
      end
   end

endmodule

//--- rtl/smcc_top.sv
// How it works
// - Level L0: straps alone configure the device
// - L1: load EEPROM as primary, then signal done
// - L1: secondary still answers during the load
// - L2: secondary only, outside primary configures
// - Source level is followed live, not only once
// - Strap mode: bank zero boost from two straps
// - Bus modes: same straps give secondary address
// - Strap mode: bank one boost from two straps
// - Strap mode: bank zero gain from strap
// - Strap mode: bank one gain from strap
// - Bank zero powerdown high powers channels down
// - Bank one powerdown high powers channels down
// - Any powerdown toggle restarts receiver detect
// - Low read enable starts the EEPROM load
// - Done holds with read enable still low
// - Signal path disabled while loading
// - Read enable ignored outside L1
// - Done released while incomplete or outside L1
// - Strap mode: receiver detect option from strap
module smcc_top (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Five-level inputs, decoded level codes
   input wire logic [2:0] config_source_level,
   input wire logic [2:0] bank_zero_boost_or_addr_sel_lo,
   input wire logic [2:0] bank_zero_boost_or_addr_sel_hi,
   input wire logic [2:0] bank_one_boost_sel_lo,
   input wire logic [2:0] bank_one_boost_sel_hi,
   input wire logic [2:0] bank_zero_flat_level_strap,
   input wire logic [2:0] bank_one_flat_level_strap,
   input wire logic [2:0] receiver_detect_option_strap,
   // Bank power-down inputs
   input wire logic bank_zero_powerdown,
   input wire logic bank_one_powerdown,
   // EEPROM load control
   input wire logic eeprom_read_en_n,
   output logic load_complete_n_out,
   output logic load_complete_n_oe_n,
   output logic load_failed,
   // Two-wire bus pins
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe_n,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   // Channel control
   output logic [4:0] bank_zero_boost,
   output logic [4:0] bank_one_boost,
   output logic [2:0] bank_zero_gain,
   output logic [2:0] bank_one_gain,
   output logic [2:0] rx_detect_option,
   output logic bank_zero_pd,
   output logic bank_one_pd,
   output logic bank_zero_path_en,
   output logic bank_one_path_en,
   output logic rx_detect_restart,
   // Status
   output logic [2:0] config_mode,
   output logic [6:0] secondary_addr
);

   // Mode tracking
   smcc_pkg::smcc_level_t mode_reg;
   smcc_pkg::smcc_level_t mode_next;
   logic mode_chg;
   logic strap_mode, eeprom_mode, bus_mode;

   // Straps
   logic [smcc_pkg::NSTRAP*3-1:0] strap_raw;
   logic [smcc_pkg::NSTRAP*3-1:0] strap_held;
   logic straps_captured;

   // Register file
   logic [7:0] cfg_reg [smcc_pkg::CFG_REGS];

   // Secondary
   logic s_sda_pull, s_busy, s_wr;
   logic [1:0] s_wr_idx, s_rd_idx;
   logic [7:0] s_wr_data;

   // Primary engine
   smcc_pkg::smcc_mstate_t mst_reg;
   logic [1:0] ph_reg;
   logic [7:0] qcnt_reg;
   logic [3:0] bitc_reg;
   logic [2:0] byte_reg;
   logic [7:0] msh_reg;
   logic m_scl_pull, m_sda_pull, m_fail_reg, m_wr;
   logic [1:0] m_wr_idx;
   logic [7:0] m_wr_data;
   logic tick, is_rd, mst_busy, load_go;
   logic [7:0] tx_next;

   // Output next values
   logic [4:0] boost0_strap, boost1_strap, boost0_next, boost1_next;
   logic [2:0] bank_zero_flat_level_strap_next, bank_one_flat_level_strap_next, rxd_next;
   logic [6:0] addr_next;
   logic loading, pd_toggle;

   assign mode_next = smcc_pkg::lvl_clamp(config_source_level);
   assign mode_chg = (mode_next != mode_reg);
   assign eeprom_mode = (mode_reg == smcc_pkg::LVL_L1);
   // Test levels fall back to strap behaviour, no bus activity
   assign strap_mode = ~eeprom_mode & (mode_reg != smcc_pkg::LVL_L2);
   assign bus_mode = ~strap_mode;

   always_ff @(posedge clock) begin
      if (reset) begin
         mode_reg <= smcc_pkg::LVL_L0;
      end else begin
         mode_reg <= mode_next;
      end
   end

   assign strap_raw = {receiver_detect_option_strap, bank_one_flat_level_strap,
                       bank_zero_flat_level_strap, bank_one_boost_sel_hi,
                       bank_one_boost_sel_lo, bank_zero_boost_or_addr_sel_hi,
                       bank_zero_boost_or_addr_sel_lo};

   smcc_strap_latch u_straps (
      .clock(clock),
      .reset(reset),
      .strap_raw(strap_raw),
      .strap_held(strap_held),
      .captured(straps_captured)
   );

   smcc_secondary u_secondary (
      .clock(clock),
      .reset(reset),
      .enable(bus_mode),
      .dev_addr(secondary_addr),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .sda_pull(s_sda_pull),
      .busy(s_busy),
      .wr_en(s_wr),
      .wr_idx(s_wr_idx),
      .wr_data(s_wr_data),
      .rd_idx(s_rd_idx),
      .rd_data(cfg_reg[s_rd_idx])
   );

   // Register file; an EEPROM byte wins a same-cycle collision with a bus write
   genvar gi;
   generate
      for (gi = 0; gi < smcc_pkg::CFG_REGS; gi++) begin : g_cfg
         always_ff @(posedge clock) begin
            if (reset) begin
               cfg_reg[gi] <= smcc_pkg::CFG_RST;
            end else if (m_wr && m_wr_idx == 2'(gi)) begin
               cfg_reg[gi] <= m_wr_data;
            end else if (s_wr && s_wr_idx == 2'(gi)) begin
               cfg_reg[gi] <= s_wr_data;
            end
         end
      end
   endgenerate

   // Primary engine decode
   assign tick = (qcnt_reg == 8'h00);
   assign is_rd = (byte_reg >= smcc_pkg::BYTE_FIRST_RD);
   assign mst_busy = (mst_reg == smcc_pkg::M_START) | (mst_reg == smcc_pkg::M_BITS) |
                     (mst_reg == smcc_pkg::M_STOP);
   // Waiting for a free bus keeps a second primary's transfer intact
   assign load_go = eeprom_mode & ~eeprom_read_en_n & straps_captured & ~s_busy;
   assign tx_next = (byte_reg == 3'h0) ? smcc_pkg::EEPROM_START_OFS :
                    {smcc_pkg::EEPROM_ADDR, 1'b1};

   always_ff @(posedge clock) begin
      if (reset) begin
         mst_reg <= smcc_pkg::M_IDLE;
         ph_reg <= 2'h0;
         qcnt_reg <= smcc_pkg::QTR_CNT;
         bitc_reg <= 4'h0;
         byte_reg <= 3'h0;
         msh_reg <= 8'h00;
         {m_scl_pull, m_sda_pull, m_fail_reg, m_wr} <= 4'h0;
         m_wr_idx <= 2'h0;
         m_wr_data <= 8'h00;
      end else begin
         m_wr <= 1'b0;
         qcnt_reg <= (tick || !mst_busy) ? smcc_pkg::QTR_CNT : qcnt_reg - 8'h01;
         if (mode_chg) begin
            mst_reg <= smcc_pkg::M_IDLE;
            {m_scl_pull, m_sda_pull} <= 2'h0;
         end else begin
            case (mst_reg)
               smcc_pkg::M_IDLE: begin
                  if (load_go) begin
                     mst_reg <= smcc_pkg::M_START;
                     ph_reg <= 2'h0;
                     byte_reg <= 3'h0;
                     m_fail_reg <= 1'b0;
                     msh_reg <= {smcc_pkg::EEPROM_ADDR, 1'b0};
                  end
               end
               smcc_pkg::M_START: begin
                  if (tick) begin
                     ph_reg <= ph_reg + 2'h1;
                     case (ph_reg)
                        2'h0: m_sda_pull <= 1'b0;
                        2'h1: m_scl_pull <= 1'b0;
                        2'h2: m_sda_pull <= 1'b1;
                        default: begin
                           m_scl_pull <= 1'b1;
                           bitc_reg <= 4'h0;
                           mst_reg <= smcc_pkg::M_BITS;
                        end
                     endcase
                  end
               end
               smcc_pkg::M_BITS: begin
                  if (tick) begin
                     ph_reg <= ph_reg + 2'h1;
                     case (ph_reg)
                        2'h0: begin
                           if (bitc_reg < 4'h8) begin
                              m_sda_pull <= ~is_rd & ~msh_reg[7];
                           end else begin
                              m_sda_pull <= is_rd & (byte_reg != smcc_pkg::BYTE_LAST);
                           end
                        end
                        2'h1: m_scl_pull <= 1'b0;
                        2'h2: begin
                           if (bitc_reg < 4'h8 && is_rd) begin
                              msh_reg <= {msh_reg[6:0], sda_in};
                           end else if (bitc_reg < 4'h8 && msh_reg[7] && !sda_in) begin
                              // Lost arbitration: back off and retry on a free bus
                              mst_reg <= smcc_pkg::M_IDLE;
                              {m_scl_pull, m_sda_pull} <= 2'h0;
                           end else if (bitc_reg < 4'h8) begin
                              msh_reg <= {msh_reg[6:0], 1'b0};
                           end else if (!is_rd && sda_in) begin
                              m_fail_reg <= 1'b1;
                              mst_reg <= smcc_pkg::M_STOP;
                              ph_reg <= 2'h0;
                           end
                        end
                        default: begin
                           m_scl_pull <= 1'b1;
                           bitc_reg <= (bitc_reg == 4'h8) ? 4'h0 : bitc_reg + 4'h1;
                           if (bitc_reg == 4'h8) begin
                              byte_reg <= byte_reg + 3'h1;
                              msh_reg <= tx_next;
                              if (is_rd) begin
                                 m_wr <= 1'b1;
                                 m_wr_idx <= 2'(byte_reg - smcc_pkg::BYTE_FIRST_RD);
                                 m_wr_data <= msh_reg;
                              end
                              if (byte_reg == smcc_pkg::BYTE_LAST) begin
                                 mst_reg <= smcc_pkg::M_STOP;
                              end else if (byte_reg == 3'h1) begin
                                 mst_reg <= smcc_pkg::M_START;
                              end
                           end
                        end
                     endcase
                  end
               end
               smcc_pkg::M_STOP: begin
                  if (tick) begin
                     ph_reg <= ph_reg + 2'h1;
                     case (ph_reg)
                        2'h0: m_sda_pull <= 1'b1;
                        2'h1: m_scl_pull <= 1'b0;
                        2'h2: m_sda_pull <= 1'b0;
                        default: begin
                           mst_reg <= m_fail_reg ? smcc_pkg::M_FAIL : smcc_pkg::M_DONE;
                        end
                     endcase
                  end
               end
               smcc_pkg::M_DONE: begin
                  mst_reg <= smcc_pkg::M_DONE;
               end
               smcc_pkg::M_FAIL: begin
                  // A fresh falling read enable retries the load
                  if (eeprom_read_en_n) begin
                     mst_reg <= smcc_pkg::M_IDLE;
                  end
               end
               default: begin
                  mst_reg <= smcc_pkg::M_IDLE;
               end
            endcase
         end
      end
   end

   // Output selection
   assign boost0_strap = smcc_pkg::pair_index(strap_held[smcc_pkg::ST_B0LO*3 +: 3],
                                              strap_held[smcc_pkg::ST_B0HI*3 +: 3]);
   assign boost1_strap = smcc_pkg::pair_index(strap_held[smcc_pkg::ST_B1LO*3 +: 3],
                                              strap_held[smcc_pkg::ST_B1HI*3 +: 3]);
   assign boost0_next = strap_mode ? boost0_strap :
                        cfg_reg[smcc_pkg::REG_BOOST0][4:0];
   assign boost1_next = strap_mode ? boost1_strap :
                        cfg_reg[smcc_pkg::REG_BOOST1][4:0];
   assign bank_zero_flat_level_strap_next = strap_mode ? strap_held[smcc_pkg::ST_G0*3 +: 3] :
                       cfg_reg[smcc_pkg::REG_GAIN][2:0];
   assign bank_one_flat_level_strap_next = strap_mode ? strap_held[smcc_pkg::ST_G1*3 +: 3] :
                       cfg_reg[smcc_pkg::REG_GAIN][6:4];
   assign rxd_next = strap_mode ? strap_held[smcc_pkg::ST_RXD*3 +: 3] :
                     cfg_reg[smcc_pkg::REG_RXDET][2:0];
   assign addr_next = smcc_pkg::SEC_ADDR_BASE + {2'h0, boost0_strap};
   assign loading = eeprom_mode & mst_busy;
   assign pd_toggle = (bank_zero_powerdown ^ bank_zero_pd) |
                      (bank_one_powerdown ^ bank_one_pd);

   always_ff @(posedge clock) begin
      if (reset) begin
         bank_zero_boost <= 5'h00;
         bank_one_boost <= 5'h00;
         bank_zero_gain <= 3'h0;
         bank_one_gain <= 3'h0;
         rx_detect_option <= 3'h0;
         secondary_addr <= smcc_pkg::SEC_ADDR_BASE;
         config_mode <= smcc_pkg::LVL_L0;
         {bank_zero_pd, bank_one_pd, rx_detect_restart} <= 3'h0;
         {bank_zero_path_en, bank_one_path_en} <= 2'h0;
         {load_complete_n_out, scl_out, sda_out, load_failed} <= 4'h0;
         {load_complete_n_oe_n, scl_oe_n, sda_oe_n} <= 3'h7;
      end else begin
         bank_zero_boost <= boost0_next;
         bank_one_boost <= boost1_next;
         bank_zero_gain <= bank_zero_flat_level_strap_next;
         bank_one_gain <= bank_one_flat_level_strap_next;
         rx_detect_option <= rxd_next;
         secondary_addr <= addr_next;
         config_mode <= mode_reg;
         bank_zero_pd <= bank_zero_powerdown;
         bank_one_pd <= bank_one_powerdown;
         rx_detect_restart <= pd_toggle;
         bank_zero_path_en <= ~bank_zero_powerdown & ~loading;
         bank_one_path_en <= ~bank_one_powerdown & ~loading;
         load_complete_n_oe_n <= ~(eeprom_mode & (mst_reg == smcc_pkg::M_DONE));
         load_failed <= eeprom_mode & (mst_reg == smcc_pkg::M_FAIL);
         scl_oe_n <= ~m_scl_pull;
         sda_oe_n <= ~(m_sda_pull | s_sda_pull);
      end
   end

endmodule

//--- verification/smcc_checker.sv
module smcc_checker (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Watched pins
   input wire logic bank_zero_powerdown,
   input wire logic bank_one_powerdown,
   input wire logic load_complete_n_out,
   input wire logic load_complete_n_oe_n,
   input wire logic scl_oe_n,
   input wire logic sda_oe_n,
   input wire logic bank_zero_pd,
   input wire logic bank_one_pd,
   input wire logic bank_zero_path_en,
   input wire logic rx_detect_restart,
   input wire logic [2:0] config_mode
);
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   sequence s_pd0_rise;
      !bank_zero_powerdown ##1 bank_zero_powerdown;
   endsequence
   AST_PD0_COPY: assert property (!$past(reset) |-> bank_zero_pd == $past(bank_zero_powerdown))
      else $error("bank zero power-down not followed");
   AST_PD1_COPY: assert property (!$past(reset) |-> bank_one_pd == $past(bank_one_powerdown))
      else $error("bank one power-down not followed");
   AST_PD0_RESTART: assert property (s_pd0_rise |=> rx_detect_restart && !bank_zero_path_en)
      else $error("power-down toggle gave no restart");
   AST_DONE_LOW: assert property (load_complete_n_out == 1'b0)
      else $error("done pin would drive high");
   AST_DONE_HOLD: assert property (!load_complete_n_oe_n ##1 config_mode == smcc_pkg::LVL_L1
      |-> !load_complete_n_oe_n) else $error("done dropped while in L1");
   AST_DONE_OFF: assert property (config_mode != smcc_pkg::LVL_L1
      && $past(config_mode) != smcc_pkg::LVL_L1 |-> load_complete_n_oe_n) else $error("done driven");
   AST_L0_QUIET: assert property (config_mode == smcc_pkg::LVL_L0
      && $past(config_mode) == smcc_pkg::LVL_L0 |-> scl_oe_n && sda_oe_n) else $error("bus used");
   AST_LOAD_PATH: assert property (!scl_oe_n |-> !bank_zero_path_en)
      else $error("path enabled during load");
endmodule
bind smcc_top smcc_checker i_smcc_checker (.*);

//--- verification/smcc_eeprom_model.sv
module smcc_eeprom_model (
   // Bus lines
   input wire logic scl,
   input wire logic sda,
   output logic sda_pull,
   // Refuses every address when high
   input wire logic refuse
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] shift_reg = 8'h00;
   logic [7:0] mem [4] = '{8'h0b, 8'h13, 8'h52, 8'h05};
   int bit_cnt = 0;
   int byte_cnt = 0;
   logic reading = 1'b0;
   initial sda_pull = 1'b0;
   always @(negedge sda) if (scl) begin
      bit_cnt = 0;
      byte_cnt = 0;
      reading = 1'b0;
   end
   always @(posedge scl) begin
      if (bit_cnt < 8) shift_reg = {shift_reg[6:0], sda};
      if (bit_cnt == 8 && byte_cnt == 0) reading = !refuse && shift_reg == 8'ha1;
      byte_cnt = byte_cnt + (bit_cnt == 8);
      bit_cnt = (bit_cnt == 8) ? 0 : bit_cnt + 1;
   end
   // Only data and ack bits are driven, so the pull-up shows elsewhere
   always @(negedge scl) begin
      if (reading) sda_pull = bit_cnt < 8 && byte_cnt < 5 && !mem[byte_cnt-1][7-bit_cnt];
      else sda_pull = bit_cnt == 8 && !refuse && (byte_cnt > 0 || shift_reg[7:1] == 7'h50);
   end
endmodule

//--- verification/test_smcc_top.sv
module test_smcc_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic [2:0] config_source_level = 3'h0;
   logic [2:0] bank_zero_boost_or_addr_sel_lo = 3'h2;
   logic [2:0] bank_zero_boost_or_addr_sel_hi = 3'h3;
   logic [2:0] bank_one_boost_sel_lo = 3'h1;
   logic [2:0] bank_one_boost_sel_hi = 3'h4;
   logic [2:0] bank_zero_flat_level_strap = 3'h3;
   logic [2:0] bank_one_flat_level_strap = 3'h1;
   logic [2:0] receiver_detect_option_strap = 3'h4;
   logic bank_zero_powerdown = 1'b0, bank_one_powerdown = 1'b0, eeprom_read_en_n = 1'b1;
   logic load_complete_n_out, load_complete_n_oe_n, load_failed, scl_out, scl_oe_n, sda_out;
   logic sda_oe_n, bank_zero_pd, bank_one_pd, bank_zero_path_en, bank_one_path_en;
   logic rx_detect_restart, refuse = 1'b0, scl_tb = 1'b1, sda_tb = 1'b1;
   logic [4:0] bank_zero_boost, bank_one_boost;
   logic [2:0] bank_zero_gain, bank_one_gain, rx_detect_option, config_mode;
   logic [6:0] secondary_addr;
   wire sda_pull;
   wire scl_in = scl_oe_n & scl_tb;
   wire sda_in = sda_oe_n & !sda_pull & sda_tb;
   int miscompares = 0, samples_checked = 0, n;
   smcc_top i_smcc_top (.*);
   smcc_eeprom_model i_smcc_eeprom_model (.scl(scl_in), .sda(sda_in), .sda_pull(sda_pull),
      .refuse(refuse));
   initial forever #25 clock = ~clock;
   task automatic tick(input int k);
      repeat (k) @(posedge clock);
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task finish_test;
      $display("miscompares=%0d samples_checked=%0d", miscompares, samples_checked);
      if (miscompares == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task t_straps;
      tick(2);
      bank_one_flat_level_strap <= 3'h0;
      tick(3);
      #1 chk(bank_zero_boost, 8'h11);
      chk(bank_one_boost, 8'h15);
      chk(bank_zero_gain, 8'h03);
      chk(bank_one_gain, 8'h01);
      chk(rx_detect_option, 8'h04);
      chk(secondary_addr, 8'(smcc_pkg::SEC_ADDR_BASE + 7'h11));
   endtask
   task t_pd;
      for (n = 0; n < 4; n++) begin
         @(posedge clock);
         if (n < 2) bank_zero_powerdown <= !bank_zero_powerdown;
         else bank_one_powerdown <= !bank_one_powerdown;
         @(posedge clock);
         #1 chk({bank_one_pd, bank_zero_pd}, {n == 2, n == 0});
         chk({bank_one_path_en, bank_zero_path_en}, {n != 2, n != 0});
         chk(rx_detect_restart, 8'h01);
         @(posedge clock);
         #1 chk(rx_detect_restart, 8'h00);
      end
   endtask
   task t_load_fail;
      @(posedge clock);
      config_source_level <= smcc_pkg::LVL_L1;
      tick(300);
      #1 chk(scl_oe_n, 8'h01);
      @(posedge clock);
      refuse <= 1'b1;
      eeprom_read_en_n <= 1'b0;
      for (n = 0; n < 20000 && load_failed !== 1'b1; n++) @(posedge clock);
      #1 chk(load_failed, 8'h01);
      chk(load_complete_n_oe_n, 8'h01);
      @(posedge clock);
      eeprom_read_en_n <= 1'b1;
      refuse <= 1'b0;
      tick(2);
      eeprom_read_en_n <= 1'b0;
      for (n = 0; n < 2000 && scl_oe_n === 1'b1; n++) @(posedge clock);
      #1 chk({scl_out, sda_out, bank_one_path_en, bank_zero_path_en}, 8'h00);
      for (n = 0; n < 30000 && load_complete_n_oe_n !== 1'b0; n++) @(posedge clock);
      tick(3);
      #1 chk(load_complete_n_oe_n, 8'h00);
      chk({bank_one_boost, bank_zero_boost}, 10'h26b);
      chk({bank_one_gain, bank_zero_gain, rx_detect_option}, 9'h155);
      tick(1000);
      #1 chk({load_complete_n_oe_n, scl_oe_n}, 8'h01);
   endtask
   task t_modes;
      @(posedge clock);
      config_source_level <= smcc_pkg::LVL_L0;
      tick(3);
      #1 chk({load_complete_n_oe_n, bank_zero_boost}, 8'h31);
      @(posedge clock);
      config_source_level <= smcc_pkg::LVL_L2;
      tick(300);
      sda_tb <= 1'b0;
      #1 chk({load_complete_n_oe_n, scl_oe_n}, 8'h03);
      for (n = 8; n >= 0; n--) begin
         tick(4);
         scl_tb <= 1'b0;
         tick(4);
         sda_tb <= 1'(9'h0a5 >> n);
         tick(4);
         scl_tb <= 1'b1;
      end
      #1 chk(sda_oe_n, 8'h00);
   endtask
   initial begin
      tick(20);
      reset <= 1'b0;
      t_straps;
      t_pd;
      t_load_fail;
      t_modes;
      finish_test;
   end
   initial begin
      repeat (60000) @(posedge clock);
      miscompares++;
      finish_test;
   end
endmodule
